// >>> hdl/ebt_engine.v
// Event-triggered block transfer engine with APB control and memory master port
//
// Our own choices: the register offsets and register access over APB.
`include "ebt_defines.vh"

// How it works
// - Enabled event fetches info start address from that source's vector entry.
// - Info words load mode, address and count registers, then data moves.
// - After the block (after each unit outside block mode), updated mode, address and count are written back.
// - Mode, address and count registers have no APB path; memory loads only.
// - Block mode: count upper byte is block size, lower byte counts units.
// - Block count register holds remaining blocks; one block per activation.
// - Mode register A selects mode, unit size and source step.
// - Mode register B selects block side and destination step.
// - Source address gives each read, destination address each write.
// - Per-source enable bits gate activation; cleared bit starts nothing.
// - Full activation reads vector first, then information, then moves data.
// - Read-skip bit set lets a later activation of the same last source reuse held information.
// - Vector address is vector base plus source offset.
// - Unit size code 00 selects byte transfers.
// - Source step code 10 increments the source address per unit.
// - Destination step code 10 increments destination address per unit.
// - Block side 0 means destination is block area; 1 means source.
module ebt_engine (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [7:0]  irq_req_i,
  output reg  [7:0]  irq_ack_o,
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg  [1:0]  mem_size_o,
  output reg  [31:0] mem_addr_o,
  output reg  [31:0] mem_wdata_o,
  input  wire        mem_ack_i,
  input  wire [31:0] mem_rdata_i,
  output reg         busy_o,
  output reg         done_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_VEC  = 4'h1;
  localparam [3:0] ST_INF0 = 4'h2;
  localparam [3:0] ST_INF1 = 4'h3;
  localparam [3:0] ST_INF2 = 4'h4;
  localparam [3:0] ST_INF3 = 4'h5;
  localparam [3:0] ST_RD   = 4'h6;
  localparam [3:0] ST_WR   = 4'h7;
  localparam [3:0] ST_WB0  = 4'h8;
  localparam [3:0] ST_WB1  = 4'h9;
  localparam [3:0] ST_WB2  = 4'ha;
  localparam [3:0] ST_WB3  = 4'hb;
  localparam [3:0] ST_DONE = 4'hc;

  // ----------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------
  reg [7:0]  activation_enable_bits;
  reg        read_skip_bit;
  reg [31:0] vector_base_reg;

  // ----------------------------------------------------------------
  // Internal transfer information, memory-loaded only
  // ----------------------------------------------------------------
  reg [7:0]  mode_reg_a;
  reg [7:0]  mode_reg_b;
  reg [31:0] source_address_reg;
  reg [31:0] dest_address_reg;
  reg [7:0]  block_size_half;
  reg [7:0]  unit_counter_half;
  reg [15:0] block_count_reg;
  reg [31:0] block_start_addr;

  reg [3:0]  state;
  reg [2:0]  cur_src;
  reg [2:0]  last_src;
  reg        info_valid;
  reg [31:0] info_addr;
  reg [7:0]  src_sync1;
  reg [7:0]  src_sync2;
  reg [7:0]  src_sync3;
  reg [7:0]  src_seen;

  wire [1:0] transfer_mode_field = mode_reg_a[`EBT_MRA_MODE_HI:`EBT_MRA_MODE_LO];
  wire [1:0] unit_size_field     = mode_reg_a[`EBT_MRA_SIZE_HI:`EBT_MRA_SIZE_LO];
  wire [1:0] source_step_field   = mode_reg_a[`EBT_MRA_SSTEP_HI:`EBT_MRA_SSTEP_LO];
  wire [1:0] dest_step_field     = mode_reg_b[`EBT_MRB_DSTEP_HI:`EBT_MRB_DSTEP_LO];
  wire       block_side_select   = mode_reg_b[`EBT_MRB_SIDE];
  wire       block_mode          = (transfer_mode_field == `EBT_MODE_BLOCK);

  wire [31:0] next_src_addr;
  wire [31:0] next_dst_addr;

  // ----------------------------------------------------------------
  // Address steppers
  // ----------------------------------------------------------------
  ebt_addr_step u_src_step (
    .addr_i (source_address_reg),
    .step_i (source_step_field),
    .size_i (unit_size_field),
    .addr_o (next_src_addr)
  );

  ebt_addr_step u_dst_step (
    .addr_i (dest_address_reg),
    .step_i (dest_step_field),
    .size_i (unit_size_field),
    .addr_o (next_dst_addr)
  );

  // ----------------------------------------------------------------
  // Request synchroniser and source selection
  // ----------------------------------------------------------------
  reg  [7:0] src_level;
  wire [7:0] src_pend  = src_level & activation_enable_bits;
  reg  [2:0] pick;
  reg        pick_vld;
  integer    i;

  always @* begin
    pick     = 3'd0;
    pick_vld = 1'b0;
    for (i = `EBT_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (src_pend[i] && !src_seen[i]) begin
        pick     = i[2:0];
        pick_vld = 1'b1;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      src_sync1 <= 8'h00;
      src_sync2 <= 8'h00;
      src_sync3 <= 8'h00;
      src_level <= 8'h00;
    end else begin
      src_sync1 <= irq_req_i;
      src_sync2 <= src_sync1;
      src_sync3 <= src_sync2;
      // Level moves only once flops two and three agree
      src_level <= (src_sync2 & src_sync3) | (src_level & (src_sync2 | src_sync3));
    end
  end

  // ----------------------------------------------------------------
  // Block-end arithmetic
  // ----------------------------------------------------------------
  wire       last_unit = (unit_counter_half == 8'h01);
  wire [7:0] next_unit = unit_counter_half - 8'h01;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apb_access = psel_i && penable_i && !pready_o;
  wire addr_ok    = (paddr_i == `EBT_OFF_ENABLE) || (paddr_i == `EBT_OFF_CONTROL) ||
                    (paddr_i == `EBT_OFF_VBASE)  || (paddr_i == `EBT_OFF_STATUS);

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pready_o               <= 1'b0;
      pslverr_o              <= 1'b0;
      prdata_o               <= 32'h0000_0000;
      activation_enable_bits <= `EBT_RST_ENABLE;
      read_skip_bit          <= `EBT_RST_CONTROL;
      vector_base_reg        <= `EBT_RST_VBASE;
    end else begin
      pready_o  <= apb_access;
      pslverr_o <= apb_access && !addr_ok;
      prdata_o  <= 32'h0000_0000;
      if (apb_access && pwrite_i) begin
        case (paddr_i)
          `EBT_OFF_ENABLE:  activation_enable_bits <= pwdata_i[7:0];
          `EBT_OFF_CONTROL: read_skip_bit <= pwdata_i[`EBT_CTL_READ_SKIP];
          `EBT_OFF_VBASE:   vector_base_reg <= pwdata_i;
          default: ;
        endcase
      end else if (apb_access) begin
        case (paddr_i)
          `EBT_OFF_ENABLE:  prdata_o <= {24'h00_0000, activation_enable_bits};
          `EBT_OFF_CONTROL: prdata_o <= {31'h0000_0000, read_skip_bit};
          `EBT_OFF_VBASE:   prdata_o <= vector_base_reg;
          `EBT_OFF_STATUS:  prdata_o <= {20'h0_0000, last_src, info_valid, state,
                                         3'h0, busy_o};
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  wire ack = mem_req_o && mem_ack_i;

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state              <= ST_IDLE;
      cur_src            <= 3'd0;
      last_src           <= 3'd0;
      info_valid         <= 1'b0;
      info_addr          <= 32'h0000_0000;
      mode_reg_a         <= 8'h00;
      mode_reg_b         <= 8'h00;
      source_address_reg <= 32'h0000_0000;
      dest_address_reg   <= 32'h0000_0000;
      block_size_half    <= 8'h00;
      unit_counter_half  <= 8'h00;
      block_count_reg    <= 16'h0000;
      block_start_addr   <= 32'h0000_0000;
      src_seen           <= 8'h00;
      mem_req_o          <= 1'b0;
      mem_we_o           <= 1'b0;
      mem_size_o         <= 2'b00;
      mem_addr_o         <= 32'h0000_0000;
      mem_wdata_o        <= 32'h0000_0000;
      irq_ack_o          <= 8'h00;
      busy_o             <= 1'b0;
      done_o             <= 1'b0;
    end else begin
      done_o    <= 1'b0;
      irq_ack_o <= 8'h00;
      src_seen  <= src_seen & src_level;
      case (state)
        ST_IDLE: begin
          busy_o <= 1'b0;
          if (pick_vld) begin
            cur_src  <= pick;
            busy_o   <= 1'b1;
            src_seen <= (src_seen & src_level) | (8'h01 << pick);
            if (read_skip_bit && info_valid && (pick == last_src)) begin
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b0;
              mem_size_o <= unit_size_field;
              mem_addr_o <= source_address_reg;
              state      <= ST_RD;
            end else begin
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b0;
              mem_size_o <= `EBT_SIZE_LONG;
              mem_addr_o <= vector_base_reg + ({29'h0, pick} * `EBT_VEC_STRIDE);
              state      <= ST_VEC;
            end
          end
        end
        ST_VEC: if (ack) begin
          info_addr  <= mem_rdata_i;
          mem_addr_o <= mem_rdata_i;
          state      <= ST_INF0;
        end
        ST_INF0: if (ack) begin
          mode_reg_a <= mem_rdata_i[31:24];
          mode_reg_b <= mem_rdata_i[23:16];
          mem_addr_o <= info_addr + `EBT_INFO_WORD1;
          state      <= ST_INF1;
        end
        ST_INF1: if (ack) begin
          source_address_reg <= mem_rdata_i;
          mem_addr_o         <= info_addr + `EBT_INFO_WORD2;
          state              <= ST_INF2;
        end
        ST_INF2: if (ack) begin
          dest_address_reg <= mem_rdata_i;
          mem_addr_o       <= info_addr + `EBT_INFO_WORD3;
          state            <= ST_INF3;
        end
        ST_INF3: if (ack) begin
          block_size_half   <= mem_rdata_i[31:24];
          unit_counter_half <= mem_rdata_i[23:16];
          block_count_reg   <= mem_rdata_i[15:0];
          block_start_addr  <= block_side_select ? source_address_reg
                                                 : dest_address_reg;
          info_valid        <= 1'b1;
          mem_size_o        <= unit_size_field;
          mem_addr_o        <= source_address_reg;
          state             <= ST_RD;
        end
        ST_RD: if (ack) begin
          mem_we_o    <= 1'b1;
          mem_addr_o  <= dest_address_reg;
          mem_wdata_o <= mem_rdata_i;
          source_address_reg <= next_src_addr;
          state       <= ST_WR;
        end
        ST_WR: if (ack) begin
          dest_address_reg <= next_dst_addr;
          if (block_mode && last_unit) begin
            unit_counter_half <= block_size_half;
            block_count_reg   <= block_count_reg - 16'h0001;
            if (block_side_select)
              source_address_reg <= block_start_addr;
            else
              dest_address_reg   <= block_start_addr;
          end else begin
            unit_counter_half <= next_unit;
          end
          if (!block_mode || last_unit) begin
            mem_size_o  <= `EBT_SIZE_LONG;
            mem_addr_o  <= info_addr;
            mem_wdata_o <= {mode_reg_a, mode_reg_b, 16'h0000};
            state       <= ST_WB0;
          end else begin
            mem_we_o   <= 1'b0;
            mem_addr_o <= source_address_reg;
            state      <= ST_RD;
          end
        end
        ST_WB0: if (ack) begin
          mem_addr_o  <= info_addr + `EBT_INFO_WORD1;
          mem_wdata_o <= source_address_reg;
          state       <= ST_WB1;
        end
        ST_WB1: if (ack) begin
          mem_addr_o  <= info_addr + `EBT_INFO_WORD2;
          mem_wdata_o <= dest_address_reg;
          state       <= ST_WB2;
        end
        ST_WB2: if (ack) begin
          mem_addr_o  <= info_addr + `EBT_INFO_WORD3;
          mem_wdata_o <= {block_size_half, unit_counter_half, block_count_reg};
          state       <= ST_WB3;
        end
        ST_WB3: if (ack) begin
          mem_req_o <= 1'b0;
          mem_we_o  <= 1'b0;
          state     <= ST_DONE;
        end
        ST_DONE: begin
          last_src            <= cur_src;
          irq_ack_o[cur_src]  <= 1'b1;
          done_o              <= 1'b1;
          busy_o              <= 1'b0;
          state               <= ST_IDLE;
        end
        default: begin
          mem_req_o <= 1'b0;
          state     <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> include/ebt_defines.vh
// Register offsets, field positions, reset values and codes of the block transfer engine
`ifndef EBT_DEFINES_VH
`define EBT_DEFINES_VH

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define EBT_OFF_ENABLE      12'h000
`define EBT_OFF_CONTROL     12'h004
`define EBT_OFF_VBASE       12'h008
`define EBT_OFF_STATUS      12'h00c
`define EBT_OFF_IRQ_STAT    12'h010

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EBT_RST_ENABLE      8'h00
`define EBT_RST_CONTROL     1'b0
`define EBT_RST_VBASE       32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EBT_CTL_READ_SKIP   0
`define EBT_MRA_MODE_HI     7
`define EBT_MRA_MODE_LO     6
`define EBT_MRA_SIZE_HI     5
`define EBT_MRA_SIZE_LO     4
`define EBT_MRA_SSTEP_HI    3
`define EBT_MRA_SSTEP_LO    2
`define EBT_MRB_SIDE        4
`define EBT_MRB_DSTEP_HI    3
`define EBT_MRB_DSTEP_LO    2

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define EBT_MODE_BLOCK      2'b10
`define EBT_SIZE_BYTE       2'b00
`define EBT_SIZE_WORD       2'b01
`define EBT_SIZE_LONG       2'b10
`define EBT_STEP_FIXED      2'b00
`define EBT_STEP_INC        2'b10
`define EBT_STEP_DEC        2'b11

// ----------------------------------------------------------------
// Vector table and information layout
// ----------------------------------------------------------------
`define EBT_VEC_STRIDE      32'h0000_0004
`define EBT_INFO_WORD1      32'h0000_0004
`define EBT_INFO_WORD2      32'h0000_0008
`define EBT_INFO_WORD3      32'h0000_000c
`define EBT_NUM_SRC         8

`endif

// >>> hdl/ebt_addr_step.v
// Address update after one unit: fixed, increment or decrement by unit size
`include "ebt_defines.vh"

module ebt_addr_step (
  input  wire [31:0] addr_i,
  input  wire [1:0]  step_i,
  input  wire [1:0]  size_i,
  output reg  [31:0] addr_o
);

  reg [31:0] unit_bytes;

  always @* begin
    case (size_i)
      `EBT_SIZE_WORD: unit_bytes = 32'h0000_0002;
      `EBT_SIZE_LONG: unit_bytes = 32'h0000_0004;
      default:        unit_bytes = 32'h0000_0001;
    endcase
    case (step_i)
      `EBT_STEP_INC: addr_o = addr_i + unit_bytes;
      `EBT_STEP_DEC: addr_o = addr_i - unit_bytes;
      default:       addr_o = addr_i;
    endcase
  end

endmodule

// >>> verification/ebt_engine_monitor.sv
// Port-level checker of the block transfer engine
module ebt_engine_monitor (
  input logic        mclk_i,
  input logic        rst_b_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  input logic [7:0]  irq_ack_o,
  input logic        mem_req_o,
  input logic        mem_we_o,
  input logic [1:0]  mem_size_o,
  input logic [31:0] mem_addr_o,
  input logic [31:0] mem_wdata_o,
  input logic        mem_ack_i,
  input logic        done_o
);
  logic [7:0]  en_sh;
  logic        skip_sh;
  logic [31:0] vb_sh;
  wire         take_wr = psel_i && penable_i && !pready_o && pwrite_i;

  // Shadow of the software settings
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      en_sh   <= 8'h00;
      skip_sh <= 1'b0;
      vb_sh   <= 32'h0;
    end else if (take_wr) begin
      if (paddr_i == 12'h000) en_sh <= pwdata_i[7:0];
      if (paddr_i == 12'h004) skip_sh <= pwdata_i[0];
      if (paddr_i == 12'h008) vb_sh <= pwdata_i;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ack_enabled_only_a: assert property ((irq_ack_o & ~en_sh) == 8'h00)
    else $error("activation acknowledged for a disabled source");
  vector_read_first_a: assert property ($rose(mem_req_o) && !skip_sh
    |-> !mem_we_o && mem_size_o == 2'b10) else $error("first access is not a long read");
  vector_addr_calc_a: assert property ($rose(mem_req_o) && !skip_sh
    |-> ((mem_addr_o - vb_sh) & 32'hffff_ffe3) == 32'h0) else $error("vector address off base");
  mem_req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
    $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_size_o) && $stable(mem_wdata_o))
    else $error("memory request changed before acknowledge");
  writeback_last_a: assert property ($fell(mem_req_o) |->
    $past(mem_we_o) && $past(mem_size_o) == 2'b10 ##[0:1] done_o)
    else $error("activation did not end with a long writeback");
  done_one_src_a: assert property (done_o |-> $onehot(irq_ack_o))
    else $error("done without a single source acknowledge");
  info_no_access_a: assert property (pready_o && paddr_i > 12'h010 |->
    pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  ack_single_pulse_a: assert property (irq_ack_o != 8'h00 |-> done_o ##1 irq_ack_o == 8'h00)
    else $error("source acknowledge not a single pulse with done");

  cover property ($rose(mem_req_o) && skip_sh);
  cover property (done_o && irq_ack_o[5]);
  cover property (pslverr_o);
endmodule

bind ebt_engine ebt_engine_monitor ebt_engine_monitor_inst (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_ack_o(irq_ack_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_size_o(mem_size_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .done_o(done_o)
);

// >>> verification/ebt_mem_model.sv
// Behavioural system memory with a variable response delay
module ebt_mem_model (
  input  logic        mclk_i,
  input  logic        rst_b_i,
  input  logic        mem_req_i,
  input  logic        mem_we_i,
  input  logic [1:0]  mem_size_i,
  input  logic [31:0] mem_addr_i,
  input  logic [31:0] mem_wdata_i,
  output logic        mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];
  int         n_rd = 0;
  int         n_wr = 0;
  int         wait_cnt = 0;
  wire [2:0]  nb = 3'd1 << mem_size_i;

  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 32'h5a5a_5a5a;
  end

  // Read data toggles outside the acknowledge so stale values never match
  always @(posedge mclk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_b_i && mem_req_i && !mem_ack_o) begin
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else begin
        mem_ack_o <= 1'b1;
        wait_cnt <= $urandom_range(0, 3);
        if (mem_we_i) n_wr <= n_wr + 1;
        else n_rd <= n_rd + 1;
        for (int i = 0; i < 4; i++) begin
          if (mem_we_i && i < nb) mem[mem_addr_i[11:0] + i] <= mem_wdata_i[8*i +: 8];
          if (!mem_we_i) mem_rdata_o[8*i +: 8] <= (i < nb) ? mem[mem_addr_i[11:0] + i] : 8'h00;
        end
      end
    end
  end
endmodule

// >>> verification/testbench.sv
// Self-checking bench of the block transfer engine
`include "ebt_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [7:0]  irq_req_i = 8'h00;
  logic [31:0] prdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic        pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack_i, busy_o, done_o;
  logic [7:0]  irq_ack_o;
  logic [1:0]  mem_size_o;
  int          fail_count = 0;
  int          n_compared = 0;

  always #20 mclk_i = ~mclk_i;

  ebt_engine ebt_engine_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_req_i(irq_req_i),
    .irq_ack_o(irq_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_size_o(mem_size_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o));
  ebt_mem_model ebt_mem_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_size_i(mem_size_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  function automatic logic [31:0] rd32(input int a);
    return {ebt_mem_model_inst.mem[a+3], ebt_mem_model_inst.mem[a+2],
            ebt_mem_model_inst.mem[a+1], ebt_mem_model_inst.mem[a]};
  endfunction
  function automatic logic [31:0] bt(input int a);
    return 32'(ebt_mem_model_inst.mem[a]);
  endfunction
  task automatic wr32(input int a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) ebt_mem_model_inst.mem[a+i] = d[8*i +: 8];
  endtask
  function automatic logic [31:0] cnt_word(input int bs, input int blocks);
    return {8'(bs), 8'(bs), 16'(blocks)};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    hang(n, 50);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // One activation of source s, with expected read and write counts
  task automatic fire(input int s, input int rd, input int wr);
    int r0, w0, n;
    r0 = ebt_mem_model_inst.n_rd;
    w0 = ebt_mem_model_inst.n_wr;
    n = 0;
    @(posedge mclk_i);
    irq_req_i[s] <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (done_o !== 1'b1 && n < 3000);
    hang(n, 3000);
    chk(32'(irq_ack_o), 32'h1 << s);
    irq_req_i[s] <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk(32'(ebt_mem_model_inst.n_rd - r0), 32'(rd));
    chk(32'(ebt_mem_model_inst.n_wr - w0), 32'(wr));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        e;
    logic [31:0] vb;
    int          n1;
    int          n2;
    void'($urandom(56146));
    n1 = $urandom_range(1, 8);
    n2 = $urandom_range(1, 8);
    vb = 32'h100 + 32'($urandom_range(0, 7)) * 32'h20;
    for (int i = 0; i < 4096; i++) ebt_mem_model_inst.mem[i] = 8'($urandom());
    wr32(vb + 12, 32'h200);
    wr32(vb + 20, 32'h240);
    wr32(32'h200, 32'h8808_0000);
    wr32(32'h204, 32'h400);
    wr32(32'h208, 32'h800);
    wr32(32'h20c, cnt_word(n1, 2));
    wr32(32'h240, 32'ha818_0000);
    wr32(32'h244, 32'h500);
    wr32(32'h248, 32'ha00);
    wr32(32'h24c, cnt_word(n2, 1));
    wr32(vb, 32'h280);
    wr32(32'h280, 32'h1c00_0000);
    wr32(32'h284, 32'h602);
    wr32(32'h288, 32'hc00);
    wr32(32'h28c, 32'h0303_0005);
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    apb(1'b0, `EBT_OFF_ENABLE, 32'h0, q, e);
    chk(q, 32'(`EBT_RST_ENABLE));
    apb(1'b0, `EBT_OFF_CONTROL, 32'h0, q, e);
    chk(q, 32'(`EBT_RST_CONTROL));
    apb(1'b0, `EBT_OFF_VBASE, 32'h0, q, e);
    chk(q, `EBT_RST_VBASE);
    apb(1'b1, 12'h0f0, 32'hffff_ffff, q, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h0f0, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, `EBT_OFF_VBASE, vb, q, e);
    apb(1'b1, `EBT_OFF_ENABLE, 32'h29, q, e);
    fire(3, 5 + n1, n1 + 4);
    for (int i = 0; i < n1; i++) chk(bt(32'h800 + i), bt(32'h400 + i));
    chk(rd32(32'h204), 32'h400 + n1);
    chk(rd32(32'h208), 32'h800);
    chk(rd32(32'h20c), cnt_word(n1, 1));
    q = rd32(32'h200);
    chk(32'(q[31:16]), 32'h8808);
    apb(1'b1, `EBT_OFF_CONTROL, 32'h1, q, e);
    fire(3, n1, n1 + 4);
    for (int i = 0; i < n1; i++) chk(bt(32'h800 + i), bt(32'h400 + n1 + i));
    chk(rd32(32'h204), 32'h400 + 2 * n1);
    chk(rd32(32'h20c), cnt_word(n1, 0));
    fire(5, 5 + n2, n2 + 4);
    for (int i = 0; i < n2; i++) chk(rd32(32'ha00 + 4 * i), rd32(32'h500 + 4 * i));
    chk(rd32(32'h244), 32'h500);
    chk(rd32(32'h248), 32'ha00 + 4 * n2);
    chk(rd32(32'h24c), cnt_word(n2, 0));
    fire(0, 6, 5);
    chk(rd32(32'hc00) & 32'hffff, rd32(32'h602) & 32'hffff);
    chk(rd32(32'h284), 32'h600);
    chk(rd32(32'h288), 32'hc00);
    apb(1'b1, `EBT_OFF_ENABLE, 32'h20, q, e);
    q = 32'(ebt_mem_model_inst.n_rd);
    irq_req_i <= 8'h48;
    repeat (20) @(posedge mclk_i);
    chk(32'(busy_o), 32'h0);
    chk(32'(ebt_mem_model_inst.n_rd), q);
    irq_req_i <= 8'h00;
    tally_and_finish();
  end
endmodule
